/* cfs_pkg.sv */
`default_nettype none
package cfs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Time base.
	localparam int CLK_HZ          = 20_000_000;
	localparam int US_PER_S        = 1_000_000;
	localparam int US_CYCLES       = CLK_HZ / US_PER_S;
	localparam int US_PER_MS_DEF   = 1000;
	localparam int MS_PER_S        = 1000;

	typedef logic [17:0] cfs_cnt_t;

	// Deglitch, relax, hiccup and watchdog intervals in their own units.
	localparam int INPUT_OVERVOLTAGE_RISE_US    = 100;
	localparam int INPUT_OVERVOLTAGE_FALL_MS    = 1;
	localparam int OC_RISE_US_DEF  = 250;
	localparam int OC_FALL_MS      = 250;
	localparam int DISCHARGE_OVERCURRENT_RELAX_MS  = 250;
	localparam int UV_DEGLITCH_MS  = 2;
	localparam int HICCUP_OFF_MS   = 500;
	localparam int HICCUP_RETRY_MS = 10;
	localparam int HICCUP_WINDOW_S = 90;
	localparam int WDT_LONG_S      = 175;
	localparam int WDT_MID_S       = 88;
	localparam int WDT_SHORT_S     = 5;
	localparam logic [2:0] HICCUP_MAX_FAILS = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Indices of the synchronised comparator and pin inputs.
	localparam int SI_VBUS_OV_RISE = 0;
	localparam int SI_VBUS_OV_FALL = 1;
	localparam int SI_IIN_133      = 2;
	localparam int SI_IIN_200      = 3;
	localparam int SI_SYS_OV       = 4;
	localparam int SI_BAT_104      = 5;
	localparam int SI_BAT_102      = 6;
	localparam int SI_DCHG_133     = 7;
	localparam int SI_DCHG_200     = 8;
	localparam int SI_DCHG_100MV   = 9;
	localparam int SI_DCHG_360MV   = 10;
	localparam int SI_BAT_3V       = 11;
	localparam int SI_BAT_VMIN     = 12;
	localparam int SI_SYS_UV       = 13;
	localparam int SI_TJ_155       = 14;
	localparam int SI_TJ_135       = 15;
	localparam int SI_ADAPTER      = 16;
	localparam int SI_CELL_LO      = 17;
	localparam int SI_CELL_HI      = 18;
	localparam int NSYNC           = 19;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses.
	localparam logic [7:0] ADDR_CHG_CURRENT = 8'h00;
	localparam logic [7:0] ADDR_CHG_VOLTAGE = 8'h04;
	localparam logic [7:0] ADDR_CONTROL     = 8'h08;
	localparam logic [7:0] ADDR_STATUS      = 8'h0C;

	// Control register fields.
	localparam int CTL_WDT_LO      = 0;
	localparam int CTL_WDT_HI      = 1;
	localparam int CTL_IOC_EN      = 2;
	localparam int CTL_IOC_SEL     = 3;
	localparam int CTL_BOC_EN      = 4;
	localparam int CTL_BOC_SEL     = 5;
	localparam int CTL_UV_DIS      = 6;
	localparam int CTL_UV_NORETRY  = 7;
	localparam logic [7:0] CTL_RESET = 8'h03;

	// Status register fields.
	localparam int ST_IOC_FLAG     = 0;
	localparam int ST_SYSOV_FLAG   = 1;
	localparam int ST_BOC_FLAG     = 2;
	localparam int ST_UV_FLAG      = 3;
	localparam int ST_TH_FLAG      = 4;
	localparam int ST_IN_OV        = 8;
	localparam int ST_WDT_EXP      = 9;
	localparam int ST_CONV_EN      = 10;
	localparam int ST_BAT_OV       = 11;
	localparam int ST_CELLS_LO     = 12;
	localparam int ST_CELLS_HI     = 13;

	// Watchdog select codes.
	localparam logic [1:0] WDT_OFF   = 2'h0;
	localparam logic [1:0] WDT_SHORT = 2'h1;
	localparam logic [1:0] WDT_MID   = 2'h2;

	// Default charge voltage per cell count, 8 mV per step.
	localparam logic [11:0] CV_1S = 12'h20D;
	localparam logic [11:0] CV_2S = 12'h41A;
	localparam logic [11:0] CV_3S = 12'h627;
	localparam logic [11:0] CV_4S = 12'h834;
	localparam logic [1:0]  CELLS_1S = 2'h0;
	localparam logic [1:0]  CELLS_2S = 2'h1;
	localparam logic [1:0]  CELLS_3S = 2'h2;

	// System overvoltage threshold codes: 6 V, 12 V, 19.5 V.
	localparam logic [1:0] OVP_6V    = 2'h0;
	localparam logic [1:0] OVP_12V   = 2'h1;
	localparam logic [1:0] OVP_19V5  = 2'h2;

	// Charge current cap codes: none, 384 mA, 2 A.
	localparam logic [1:0] CAP_NONE  = 2'h0;
	localparam logic [1:0] CAP_384MA = 2'h1;
	localparam logic [1:0] CAP_2A    = 2'h2;

	localparam int HTRANS_ACTIVE = 1;

	typedef enum logic [1:0] {
		CFS_UV_RUN,
		CFS_UV_OFF,
		CFS_UV_RETRY,
		CFS_UV_LATCH
	} cfs_uv_t;

endpackage : cfs_pkg
`default_nettype wire

/* cfs_thermal_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cfs_thermal_model (
	// Die temperature in degrees.
	input  wire logic [7:0]	tj_degc,
	// Comparator outputs.
	output logic		tj_above_155c,
	output logic		tj_above_135c
);
	assign tj_above_155c = tj_degc >= 8'h9B;
	assign tj_above_135c = tj_degc >= 8'h87;
endmodule : cfs_thermal_model
`default_nettype wire

/* cfs_top.sv */
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cfs_top
	import cfs_pkg::*;
#(
	parameter int US_PER_MS  = US_PER_MS_DEF,
	parameter int OC_RISE_US = OC_RISE_US_DEF
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Analog comparator results and pins.
	input  wire logic        vbus_above_ov_rise,
	input  wire logic        vbus_above_ov_fall,
	input  wire logic        iin_above_133pct,
	input  wire logic        iin_above_200pct,
	input  wire logic        vsys_above_ovp,
	input  wire logic        vbat_above_104pct,
	input  wire logic        vbat_above_102pct,
	input  wire logic        idchg_above_133pct,
	input  wire logic        idchg_above_200pct,
	input  wire logic        idchg_above_100mv,
	input  wire logic        idchg_above_360mv,
	input  wire logic        vbat_below_3v,
	input  wire logic        vbat_below_min_system_voltage,
	input  wire logic        vsys_below_uv,
	input  wire logic        tj_above_155c,
	input  wire logic        tj_above_135c,
	input  wire logic        adapter_present,
	input  wire logic [1:0]  cell_config_pin,
	// Controls to the power stage.
	output logic             converter_en,
	output logic             adapter_good_out,
	output logic             switches_off,
	output logic             sys_discharge_en,
	output logic             input_current_clamp,
	output logic      [1:0]  charge_cap_code,
	output logic      [1:0]  sys_ov_threshold_sel,
	output logic      [6:0]  charge_current_limit,
	output logic      [11:0] charge_voltage_limit
);

	////////////////////////////////////////////////////////////////////////////////
	// State.
	typedef struct packed {
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [4:0]       us_div;
		logic [9:0]       ms_div;
		logic             tick_us;
		logic             tick_ms;
		cfs_cnt_t         ov_cnt;
		logic             in_ov;
		cfs_cnt_t         ioc_cnt;
		logic             in_oc;
		cfs_cnt_t         boc_cnt;
		logic             bat_oc;
		logic             bat_ov;
		logic             hot;
		cfs_cnt_t         uv_cnt;
		cfs_uv_t          uv_st;
		cfs_cnt_t         uv_tmr;
		logic [2:0]       uv_fails;
		cfs_cnt_t         uv_win;
		cfs_cnt_t         wdt_cnt;
		logic             wdt_exp;
		logic             adapter_d;
		logic [6:0]       cc;
		logic [11:0]      cv;
		logic             cv_written;
		logic [1:0]       cells;
		logic [7:0]       ctl;
		logic             ioc_flag;
		logic             sysov_flag;
		logic             boc_flag;
		logic             uv_flag;
		logic             th_flag;
		logic             dp_wr;
		logic [7:0]       dp_addr;
		logic [31:0]      rdata;
		logic             ready;
		logic             conv_en;
		logic             adapter_good;
		logic             fets_off;
		logic             sys_dis;
		logic             iin_clamp;
		logic [1:0]       cap;
		logic [1:0]       ovp_sel;
	} cfs_state_t;

	cfs_state_t st_reg;
	cfs_state_t st_next;

	// Counter step: restarts when the condition drops, saturates at the limit.
	// Expiry waits for one more tick after saturation, so a full interval has passed.
	function automatic cfs_cnt_t dg_step(input cfs_cnt_t c, input logic cond,
		input logic tick, input cfs_cnt_t lim);
		if (!cond) begin
			dg_step = '0;
		end else if (tick && (c != lim)) begin
			dg_step = c + 18'h00001;
		end else begin
			dg_step = c;
		end
	endfunction : dg_step

	function automatic cfs_cnt_t wdt_limit(input logic [1:0] sel);
		case (sel)
			WDT_SHORT: wdt_limit = cfs_cnt_t'(WDT_SHORT_S * MS_PER_S);
			WDT_MID:   wdt_limit = cfs_cnt_t'(WDT_MID_S * MS_PER_S);
			default:   wdt_limit = cfs_cnt_t'(WDT_LONG_S * MS_PER_S);
		endcase
	endfunction : wdt_limit

	function automatic logic [11:0] cv_default(input logic [1:0] cells);
		case (cells)
			CELLS_1S: cv_default = CV_1S;
			CELLS_2S: cv_default = CV_2S;
			CELLS_3S: cv_default = CV_3S;
			default:  cv_default = CV_4S;
		endcase
	endfunction : cv_default

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		logic [NSYNC-1:0] in_raw;
		logic [NSYNC-1:0] sy;
		logic             addr_ph;
		logic             wr_cc;
		logic             wr_cv;
		logic             wr_ctl;
		logic             wr_st;
		logic             rd_st;
		logic             charging;
		logic             ioc_trip;
		logic             boc_above;
		logic             boc_trip;
		logic             uv_deg;
		logic             uv_off;
		cfs_cnt_t         lim;
		logic [31:0]      rmux;
		addr_ph = 1'b0;
		wr_cc = 1'b0;
		wr_cv = 1'b0;
		wr_ctl = 1'b0;
		wr_st = 1'b0;
		rd_st = 1'b0;
		charging = 1'b0;
		ioc_trip = 1'b0;
		boc_above = 1'b0;
		boc_trip = 1'b0;
		uv_deg = 1'b0;
		uv_off = 1'b0;
		lim = '0;
		rmux = '0;
		in_raw = '0;
		sy = st_reg.s2;
		st_next = st_reg;
		in_raw[SI_VBUS_OV_RISE] = vbus_above_ov_rise;
		in_raw[SI_VBUS_OV_FALL] = vbus_above_ov_fall;
		in_raw[SI_IIN_133] = iin_above_133pct;
		in_raw[SI_IIN_200] = iin_above_200pct;
		in_raw[SI_SYS_OV] = vsys_above_ovp;
		in_raw[SI_BAT_104] = vbat_above_104pct;
		in_raw[SI_BAT_102] = vbat_above_102pct;
		in_raw[SI_DCHG_133] = idchg_above_133pct;
		in_raw[SI_DCHG_200] = idchg_above_200pct;
		in_raw[SI_DCHG_100MV] = idchg_above_100mv;
		in_raw[SI_DCHG_360MV] = idchg_above_360mv;
		in_raw[SI_BAT_3V] = vbat_below_3v;
		in_raw[SI_BAT_VMIN] = vbat_below_min_system_voltage;
		in_raw[SI_SYS_UV] = vsys_below_uv;
		in_raw[SI_TJ_155] = tj_above_155c;
		in_raw[SI_TJ_135] = tj_above_135c;
		in_raw[SI_ADAPTER] = adapter_present;
		in_raw[SI_CELL_HI:SI_CELL_LO] = cell_config_pin;
		st_next.s1 = in_raw;
		st_next.s2 = st_reg.s1;

		st_next.tick_us = (st_reg.us_div == 5'(US_CYCLES - 1));
		st_next.us_div = st_next.tick_us ? 5'h00 : st_reg.us_div + 5'h01;
		st_next.tick_ms = 1'b0;
		if (st_reg.tick_us) begin
			st_next.tick_ms = (st_reg.ms_div == 10'(US_PER_MS - 1));
			st_next.ms_div = st_next.tick_ms ? 10'h000 : st_reg.ms_div + 10'h001;
		end

		// Bus decode: reads are sampled in the address phase and answer in the data phase, writes land in the data phase.
		addr_ph = hsel && hready && htrans[HTRANS_ACTIVE];
		st_next.dp_wr = addr_ph && hwrite;
		st_next.dp_addr = haddr[7:0];
		wr_cc = st_reg.dp_wr && (st_reg.dp_addr == ADDR_CHG_CURRENT);
		wr_cv = st_reg.dp_wr && (st_reg.dp_addr == ADDR_CHG_VOLTAGE);
		wr_ctl = st_reg.dp_wr && (st_reg.dp_addr == ADDR_CONTROL);
		wr_st = st_reg.dp_wr && (st_reg.dp_addr == ADDR_STATUS);
		rd_st = addr_ph && !hwrite && (haddr[7:0] == ADDR_STATUS);
		st_next.ready = 1'b1;
		rmux = '0;
		case (haddr[7:0])
			ADDR_CHG_CURRENT: rmux[6:0] = st_reg.cc;
			ADDR_CHG_VOLTAGE: rmux[11:0] = st_reg.cv;
			ADDR_CONTROL:     rmux[7:0] = st_reg.ctl;
			ADDR_STATUS: begin
				rmux[ST_IOC_FLAG] = st_reg.ioc_flag;
				rmux[ST_SYSOV_FLAG] = st_reg.sysov_flag;
				rmux[ST_BOC_FLAG] = st_reg.boc_flag;
				rmux[ST_UV_FLAG] = st_reg.uv_flag;
				rmux[ST_TH_FLAG] = st_reg.th_flag;
				rmux[ST_IN_OV] = st_reg.in_ov;
				rmux[ST_WDT_EXP] = st_reg.wdt_exp;
				rmux[ST_CONV_EN] = st_reg.conv_en;
				rmux[ST_CELLS_HI:ST_CELLS_LO] = st_reg.cells;
			end
			default: rmux = '0;
		endcase
		if (addr_ph && !hwrite) begin
			st_next.rdata = rmux;
		end

		if (wr_cc) begin
			st_next.cc = hwdata[6:0];
		end
		if (wr_ctl) begin
			st_next.ctl = hwdata[7:0];
		end
		if (wr_cv) begin
			st_next.cv = hwdata[11:0];
			st_next.cv_written = 1'b1;
		end else if (!st_reg.cv_written) begin
			st_next.cells = sy[SI_CELL_HI:SI_CELL_LO];
			st_next.cv = cv_default(st_reg.cells);
		end
		case (st_reg.cells)
			CELLS_1S: st_next.ovp_sel = OVP_6V;
			CELLS_2S: st_next.ovp_sel = OVP_12V;
			default:  st_next.ovp_sel = OVP_19V5;
		endcase

		if (wr_cc || wr_cv || wr_ctl) begin
			st_next.wdt_cnt = '0;
			st_next.wdt_exp = 1'b0;
		end else if ((st_reg.ctl[CTL_WDT_HI:CTL_WDT_LO] != WDT_OFF) && !st_reg.wdt_exp) begin
			lim = wdt_limit(st_reg.ctl[CTL_WDT_HI:CTL_WDT_LO]);
			st_next.wdt_cnt = dg_step(st_reg.wdt_cnt, 1'b1, st_reg.tick_ms, lim);
			if ((st_reg.wdt_cnt == lim) && st_reg.tick_ms) begin
				st_next.wdt_exp = 1'b1;
				st_next.cc = '0;
			end
		end
		charging = (st_reg.cc != 7'h00);

		if (!st_reg.in_ov) begin
			lim = cfs_cnt_t'(INPUT_OVERVOLTAGE_RISE_US);
			st_next.ov_cnt = dg_step(st_reg.ov_cnt, sy[SI_VBUS_OV_RISE], st_reg.tick_us, lim);
			if ((st_reg.ov_cnt == lim) && st_reg.tick_us) begin
				st_next.in_ov = 1'b1;
				st_next.ov_cnt = '0;
			end
		end else begin
			lim = cfs_cnt_t'(INPUT_OVERVOLTAGE_FALL_MS);
			st_next.ov_cnt = dg_step(st_reg.ov_cnt, !sy[SI_VBUS_OV_FALL], st_reg.tick_ms, lim);
			if ((st_reg.ov_cnt == lim) && st_reg.tick_ms) begin
				st_next.in_ov = 1'b0;
				st_next.ov_cnt = '0;
			end
		end

		ioc_trip = st_reg.ctl[CTL_IOC_SEL] ? sy[SI_IIN_200] : sy[SI_IIN_133];
		if (!st_reg.ctl[CTL_IOC_EN]) begin
			st_next.in_oc = 1'b0;
			st_next.ioc_cnt = '0;
		end else if (!st_reg.in_oc) begin
			lim = cfs_cnt_t'(OC_RISE_US);
			st_next.ioc_cnt = dg_step(st_reg.ioc_cnt, ioc_trip, st_reg.tick_us, lim);
			if ((st_reg.ioc_cnt == lim) && st_reg.tick_us) begin
				st_next.in_oc = 1'b1;
				st_next.ioc_cnt = '0;
			end
		end else begin
			lim = cfs_cnt_t'(OC_FALL_MS);
			st_next.ioc_cnt = dg_step(st_reg.ioc_cnt, !ioc_trip, st_reg.tick_ms, lim);
			if ((st_reg.ioc_cnt == lim) && st_reg.tick_ms) begin
				st_next.in_oc = 1'b0;
				st_next.ioc_cnt = '0;
			end
		end

		boc_above = st_reg.ctl[CTL_BOC_SEL] ? sy[SI_DCHG_200] : sy[SI_DCHG_133];
		boc_trip = (boc_above && sy[SI_DCHG_100MV]) || sy[SI_DCHG_360MV];
		if (!st_reg.ctl[CTL_BOC_EN]) begin
			st_next.bat_oc = 1'b0;
			st_next.boc_cnt = '0;
		end else if (!st_reg.bat_oc) begin
			lim = cfs_cnt_t'(OC_RISE_US);
			st_next.boc_cnt = dg_step(st_reg.boc_cnt, boc_trip, st_reg.tick_us, lim);
			if ((st_reg.boc_cnt == lim) && st_reg.tick_us) begin
				st_next.bat_oc = 1'b1;
				st_next.boc_cnt = '0;
			end
		end else begin
			lim = cfs_cnt_t'(DISCHARGE_OVERCURRENT_RELAX_MS);
			st_next.boc_cnt = dg_step(st_reg.boc_cnt, !boc_trip, st_reg.tick_ms, lim);
			if ((st_reg.boc_cnt == lim) && st_reg.tick_ms) begin
				st_next.bat_oc = 1'b0;
				st_next.boc_cnt = '0;
			end
		end

		if (sy[SI_BAT_104]) begin
			st_next.bat_ov = 1'b1;
		end else if (!sy[SI_BAT_102]) begin
			st_next.bat_ov = 1'b0;
		end

		if (sy[SI_TJ_155]) begin
			st_next.hot = 1'b1;
		end else if (!sy[SI_TJ_135]) begin
			st_next.hot = 1'b0;
		end

		// Sticky flags: a set in the cycle of a clear wins.
		if (rd_st) begin
			st_next.ioc_flag = 1'b0;
			st_next.boc_flag = 1'b0;
			st_next.th_flag = 1'b0;
		end
		if (wr_st && !hwdata[ST_SYSOV_FLAG]) begin
			st_next.sysov_flag = 1'b0;
		end
		st_next.adapter_d = sy[SI_ADAPTER];
		if (sy[SI_ADAPTER] && !st_reg.adapter_d) begin
			st_next.sysov_flag = 1'b0;
		end
		if (st_reg.in_oc) begin
			st_next.ioc_flag = 1'b1;
		end
		if (st_reg.bat_oc) begin
			st_next.boc_flag = 1'b1;
		end
		if (st_reg.hot) begin
			st_next.th_flag = 1'b1;
		end
		if (sy[SI_SYS_OV]) begin
			st_next.sysov_flag = 1'b1;
		end

		lim = cfs_cnt_t'(UV_DEGLITCH_MS);
		st_next.uv_cnt = dg_step(st_reg.uv_cnt, sy[SI_SYS_UV] && !st_reg.ctl[CTL_UV_DIS],
			st_reg.tick_ms, lim);
		uv_deg = (st_reg.uv_cnt == lim) && st_reg.tick_ms;
		if (st_reg.uv_fails != 3'h0) begin
			lim = cfs_cnt_t'(HICCUP_WINDOW_S * MS_PER_S);
			st_next.uv_win = dg_step(st_reg.uv_win, 1'b1, st_reg.tick_ms, lim);
			if ((st_reg.uv_win == lim) && st_reg.tick_ms) begin
				st_next.uv_fails = 3'h0;
				st_next.uv_win = '0;
			end
		end
		st_next.uv_tmr = dg_step(st_reg.uv_tmr, 1'b1, st_reg.tick_ms, '1);
		case (st_reg.uv_st)
			CFS_UV_RUN: begin
				st_next.uv_tmr = '0;
				if (uv_deg) begin
					st_next.uv_cnt = '0;
					if (st_reg.ctl[CTL_UV_NORETRY]) begin
						st_next.uv_st = CFS_UV_LATCH;
					end else begin
						st_next.uv_st = CFS_UV_OFF;
					end
				end
			end
			CFS_UV_OFF: begin
				if ((st_reg.uv_tmr == cfs_cnt_t'(HICCUP_OFF_MS)) && st_reg.tick_ms) begin
					st_next.uv_tmr = '0;
					st_next.uv_st = CFS_UV_RETRY;
				end
			end
			CFS_UV_RETRY: begin
				if (!sy[SI_SYS_UV] || st_reg.ctl[CTL_UV_DIS]) begin
					st_next.uv_st = CFS_UV_RUN;
				end else if ((st_reg.uv_tmr == cfs_cnt_t'(HICCUP_RETRY_MS)) && st_reg.tick_ms) begin
					st_next.uv_tmr = '0;
					st_next.uv_fails = st_reg.uv_fails + 3'h1;
					if (st_reg.uv_fails == HICCUP_MAX_FAILS - 3'h1) begin
						st_next.uv_st = CFS_UV_LATCH;
					end else begin
						st_next.uv_st = CFS_UV_OFF;
					end
				end
			end
			CFS_UV_LATCH: begin
				st_next.uv_flag = 1'b1;
				if (wr_st && !hwdata[ST_UV_FLAG]) begin
					st_next.uv_flag = 1'b0;
					st_next.uv_fails = 3'h0;
					st_next.uv_win = '0;
					st_next.uv_st = CFS_UV_RUN;
				end
			end
			default: st_next.uv_st = CFS_UV_RUN;
		endcase
		uv_off = (st_reg.uv_st == CFS_UV_OFF) || (st_reg.uv_st == CFS_UV_LATCH);

		// Registered outputs.
		// input limit clamp
		st_next.iin_clamp = uv_deg || (st_reg.uv_st != CFS_UV_RUN);
		st_next.fets_off = st_reg.bat_ov && charging;
		st_next.sys_dis = st_reg.bat_ov && charging;
		st_next.adapter_good = sy[SI_ADAPTER] && !st_reg.in_ov;
		st_next.conv_en = !st_reg.in_ov && !st_reg.in_oc && !st_reg.bat_oc && !st_reg.hot
			&& !st_reg.sysov_flag && !uv_off && !(st_reg.bat_ov && charging);
		st_next.cap = CAP_NONE;
		if (charging && (st_reg.cells != CELLS_1S) && sy[SI_BAT_VMIN]) begin
			st_next.cap = CAP_384MA;
		end else if (charging && (st_reg.cells == CELLS_1S)) begin
			if (sy[SI_BAT_3V]) begin
				st_next.cap = CAP_384MA;
			end else if (sy[SI_BAT_VMIN]) begin
				st_next.cap = CAP_2A;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
			st_reg.ctl <= CTL_RESET;
			st_reg.cv <= CV_1S;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata = st_reg.rdata;
	assign hreadyout = st_reg.ready;
	assign hresp = 1'b0;
	assign converter_en = st_reg.conv_en;
	assign adapter_good_out = st_reg.adapter_good;
	assign switches_off = st_reg.fets_off;
	assign sys_discharge_en = st_reg.sys_dis;
	assign input_current_clamp = st_reg.iin_clamp;
	assign charge_cap_code = st_reg.cap;
	assign sys_ov_threshold_sel = st_reg.ovp_sel;
	assign charge_current_limit = st_reg.cc;
	assign charge_voltage_limit = st_reg.cv;

endmodule : cfs_top
`default_nettype wire

/* cfs_top_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module cfs_chk
	import cfs_pkg::*;
(
	// Bus side.
	input wire logic	hclk,
	input wire logic	hresetn,
	input wire logic	hsel,
	input wire logic	hready,
	input wire logic	hwrite,
	input wire logic [1:0]	htrans,
	input wire logic [31:0]	haddr,
	input wire logic [31:0]	hwdata,
	input wire logic [31:0]	hrdata,
	input wire logic	hreadyout,
	input wire logic	hresp,
	// Power stage side.
	input wire logic	vsys_above_ovp,
	input wire logic	tj_above_155c,
	input wire logic	converter_en,
	input wire logic	switches_off,
	input wire logic	sys_discharge_en,
	input wire logic [1:0]	charge_cap_code,
	input wire logic [1:0]	sys_ov_threshold_sel,
	input wire logic [6:0]	charge_current_limit
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_cc_addr;
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == ADDR_CHG_CURRENT;
	endsequence
	sequence s_cc_data;
		s_cc_addr ##1 hwdata[6:0] != 7'h00;
	endsequence
	a_zero_wait: assert property ($past(hresetn) |-> hreadyout && !hresp)
		else $error("bus slave not zero-wait OKAY");
	a_cc_write: assert property (s_cc_data |=> charge_current_limit == $past(hwdata[6:0]))
		else $error("charge current not loaded");
	a_thermal_off: assert property (tj_above_155c [*6] |-> !converter_en)
		else $error("converter on while hot");
	a_sysov_off: assert property (vsys_above_ovp [*6] |-> !converter_en)
		else $error("converter on in system overvoltage");
	a_discharge_pair: assert property (switches_off == sys_discharge_en)
		else $error("discharge sink not paired with switch off");
	a_swoff_conv: assert property (switches_off |-> !converter_en)
		else $error("converter on while switches forced off");
	a_cap_single:
		assert property (charge_cap_code == CAP_2A |-> sys_ov_threshold_sel == OVP_6V)
		else $error("2 A cap outside single cell");
	a_code_legal:
		assert property (charge_cap_code != 2'h3 && sys_ov_threshold_sel != 2'h3)
		else $error("reserved code driven");
	a_rdata_upper: assert property (hrdata[31:14] == 18'h00000)
		else $error("read data upper bits set");
endmodule : cfs_chk
bind cfs_top cfs_chk chk_u (.*);
`default_nettype wire

/* tb_charger_fault_supervisor.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_charger_fault_supervisor;
	import cfs_pkg::*;
	logic		hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hready;
	logic [31:0]	haddr = '0, hwdata = '0, hrdata, d;
	logic [1:0]	htrans = '0, cell_config_pin = '0, charge_cap_code, sys_ov_threshold_sel;
	logic [2:0]	hsize = 3'h2;
	logic [7:0]	tj_degc = 8'h19;
	logic		vbus_above_ov_rise = '0, vbus_above_ov_fall = '0, iin_above_133pct = '0;
	logic		iin_above_200pct = '0, vsys_above_ovp = '0, vbat_above_104pct = '0;
	logic		vbat_above_102pct = '0, idchg_above_133pct = '0, idchg_above_200pct = '0;
	logic		idchg_above_100mv = '0, idchg_above_360mv = '0, vbat_below_3v = '0;
	logic		vbat_below_min_system_voltage = '0, vsys_below_uv = '0, adapter_present = '1;
	logic		tj_above_155c, tj_above_135c, hreadyout, hresp, converter_en;
	logic		adapter_good_out, switches_off, sys_discharge_en, input_current_clamp;
	logic [6:0]	charge_current_limit;
	logic [11:0]	charge_voltage_limit;
	logic [11:0]	cv [4] = '{CV_1S, CV_2S, CV_3S, CV_4S};
	logic [1:0]	ovp [4] = '{OVP_6V, OVP_12V, OVP_19V5, OVP_19V5};
	int		bad_count = 0, checked = 0;
	cfs_top #(.US_PER_MS(4), .OC_RISE_US(5)) dut_u (.*);
	cfs_thermal_model tm_u (.*);
	assign hready = hreadyout;
	initial forever #25 hclk = ~hclk;
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	// Waits for hready with a bound; a hang ends the run.
	task automatic hs;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'h1 && n < 64);
		if (n >= 64) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : hs
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hs();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		hs();
		d = hrdata;
	endtask : bus
	initial begin
		cyc(3);
		hresetn <= 1'h1;
		bus(0, ADDR_CONTROL, 0);
		chk("control", d, 32'h3);
		bus(0, 8'h10, 0);
		chk("unmapped", d, 0);
		bus(1, ADDR_CHG_CURRENT, 32'h10);
		for (int i = 0; i < 4; i++) begin
			cell_config_pin <= 2'(i);
			cyc(8);
			chk("cv", charge_voltage_limit, cv[i]);
			chk("ovp", sys_ov_threshold_sel, ovp[i]);
		end
		vbat_below_min_system_voltage <= 1'h1;
		cyc(8);
		chk("cap", charge_cap_code, CAP_384MA);
		{vbat_below_3v, cell_config_pin} <= 3'h4;
		cyc(8);
		chk("cap", charge_cap_code, CAP_384MA);
		vbat_below_3v <= 1'h0;
		cyc(8);
		chk("cap", charge_cap_code, CAP_2A);
		bus(1, ADDR_CHG_VOLTAGE, 32'h400);
		cell_config_pin <= 2'h1;
		cyc(8);
		chk("cv", charge_voltage_limit, 12'h400);
		tj_degc <= 8'hA0;
		cyc(8);
		chk("conv", converter_en, 0);
		bus(0, ADDR_STATUS, 0);
		tj_degc <= 8'h8C;
		cyc(8);
		chk("conv", converter_en, 0);
		tj_degc <= 8'h19;
		cyc(8);
		chk("conv", converter_en, 1);
		bus(0, ADDR_STATUS, 0);
		chk("thermal", d[ST_TH_FLAG], 1);
		bus(0, ADDR_STATUS, 0);
		chk("thermal", d[ST_TH_FLAG], 0);
		vsys_above_ovp <= 1'h1;
		cyc(8);
		vsys_above_ovp <= 1'h0;
		cyc(8);
		chk("conv", converter_en, 0);
		bus(0, ADDR_STATUS, 0);
		chk("sysov", d[ST_SYSOV_FLAG], 1);
		bus(1, ADDR_STATUS, 0);
		cyc(8);
		chk("conv", converter_en, 1);
		{vbus_above_ov_rise, vbus_above_ov_fall} <= 2'h3;
		cyc(US_CYCLES * INPUT_OVERVOLTAGE_RISE_US - 40);
		chk("good", adapter_good_out, 1);
		cyc(80);
		chk("good", adapter_good_out, 0);
		chk("conv", converter_en, 0);
		{vbus_above_ov_rise, vbus_above_ov_fall} <= 2'h0;
		cyc(40);
		chk("good", adapter_good_out, 0);
		cyc(200);
		chk("good", adapter_good_out, 1);
		iin_above_133pct <= 1'h1;
		cyc(300);
		chk("conv", converter_en, 1);
		bus(1, ADDR_CONTROL, 32'h7);
		cyc(300);
		chk("conv", converter_en, 0);
		iin_above_133pct <= 1'h0;
		cyc(19000);
		chk("conv", converter_en, 0);
		cyc(1500);
		chk("conv", converter_en, 1);
		bus(0, ADDR_STATUS, 0);
		chk("ocflag", d[ST_IOC_FLAG], 1);
		bus(0, ADDR_STATUS, 0);
		chk("ocflag", d[ST_IOC_FLAG], 0);
		{vbat_above_104pct, vbat_above_102pct} <= 2'h3;
		cyc(8);
		chk("swoff", switches_off, 1);
		chk("sink", sys_discharge_en, 1);
		chk("conv", converter_en, 0);
		vbat_above_104pct <= 1'h0;
		cyc(8);
		chk("swoff", switches_off, 1);
		bus(0, ADDR_STATUS, 0);
		chk("batov", d[ST_BAT_OV], 0);
		bus(1, ADDR_CHG_CURRENT, 0);
		cyc(8);
		chk("sink", sys_discharge_en, 0);
		chk("conv", converter_en, 1);
		bus(1, ADDR_CHG_CURRENT, 32'h10);
		vbat_above_102pct <= 1'h0;
		cyc(8);
		chk("swoff", switches_off, 0);
		chk("cc", charge_current_limit, 7'h10);
		bus(1, ADDR_CONTROL, 32'h37);
		{idchg_above_133pct, idchg_above_100mv} <= 2'h3;
		cyc(300);
		chk("conv", converter_en, 1);
		idchg_above_360mv <= 1'h1;
		cyc(300);
		chk("conv", converter_en, 0);
		{idchg_above_133pct, idchg_above_100mv, idchg_above_360mv} <= 3'h0;
		cyc(1000);
		chk("conv", converter_en, 0);
		bus(1, ADDR_CONTROL, 32'h07);
		cyc(8);
		chk("conv", converter_en, 1);
		bus(0, ADDR_STATUS, 0);
		chk("bocflag", d[ST_BOC_FLAG], 1);
		bus(0, ADDR_STATUS, 0);
		chk("bocflag", d[ST_BOC_FLAG], 0);
		bus(1, ADDR_CONTROL, 32'h47);
		vsys_below_uv <= 1'h1;
		cyc(400);
		chk("conv", converter_en, 1);
		chk("clamp", input_current_clamp, 0);
		bus(1, ADDR_CONTROL, 32'h87);
		cyc(400);
		chk("conv", converter_en, 0);
		chk("clamp", input_current_clamp, 1);
		vsys_below_uv <= 1'h0;
		cyc(400);
		chk("conv", converter_en, 0);
		bus(0, ADDR_STATUS, 0);
		chk("uvflag", d[ST_UV_FLAG], 1);
		bus(1, ADDR_STATUS, 0);
		cyc(8);
		chk("conv", converter_en, 1);
		chk("clamp", input_current_clamp, 0);
		bus(1, ADDR_CONTROL, 32'h07);
		vsys_below_uv <= 1'h1;
		cyc(400);
		chk("conv", converter_en, 0);
		vsys_below_uv <= 1'h0;
		bus(0, ADDR_STATUS, 0);
		chk("uvflag", d[ST_UV_FLAG], 0);
		cyc(39000);
		chk("clamp", input_current_clamp, 1);
		cyc(2000);
		chk("conv", converter_en, 1);
		tally_and_finish();
	end
endmodule : tb_charger_fault_supervisor
`default_nettype wire
